//--- rtl/ihs_pkg.sv
package ihs_pkg;
	localparam logic [6:0]  HIST_COUNT_ADDR   = 7'h46;
	localparam logic [6:0]  SPARSITY_ADDR     = 7'h47;
	localparam logic [2:0]  HIST_COUNT_RST    = 3'h0;
	localparam logic [7:0]  SPARSITY_RST      = 8'h08;
	localparam logic [7:0]  SPARSITY_MIN      = 8'h08;
	localparam logic [2:0]  HIST_MAX          = 3'h5;
	localparam int          NUM_HIST          = 5;
	localparam int          NUM_BINS          = 32;
	localparam int          NUM_CNT           = 34;
	localparam int          CNT_W             = 24;
	localparam int          WORD_W            = 12;
	localparam int          PIX_W             = 12;
	localparam int          NUM_HALF          = 2;
	localparam logic [5:0]  ELEM_MARK         = 6'h00;
	localparam logic [5:0]  ELEM_ID           = 6'h01;
	localparam logic [5:0]  ELEM_FIRST_CNT    = 6'h02;
	localparam logic [5:0]  ELEM_LAST         = 6'h23;
	localparam logic [1:0]  WIDTH_SEL_12      = 2'h2;
	localparam logic [3:0]  SHIFT_10          = 4'h5;
	localparam logic [3:0]  SHIFT_12          = 4'h7;
	localparam logic [11:0] MAX_10            = 12'h3FF;
	localparam logic [11:0] MAX_12            = 12'hFFF;
	localparam logic [11:0] MASK_10           = 12'h3FF;

	typedef enum logic [1:0] {
		S_ACC,
		S_WAIT_ROW,
		S_SEND,
		S_CLR
	} ihs_state_t;
endpackage : ihs_pkg

//--- rtl/ihs_buf.sv
`timescale 1ns/100ps
module ihs_buf #(
	parameter int W = 24
) (
	// Clock and reset.
	input  wire logic         i_sys_clk,
	input  wire logic         i_arst_n,
	// Fill side.
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	// Drain side.
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wp;
		logic              rp;
		logic [1:0]        cnt;
	} ihs_buf_st_t;

	ihs_buf_st_t st_r;
	ihs_buf_st_t st_nxt;
	logic        push;
	logic        pop;

	assign o_in_ready  = (st_r.cnt != 2'h2);
	assign o_out_valid = (st_r.cnt != 2'h0);
	assign o_out_data  = st_r.mem[st_r.rp];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = i_in_data;
			st_nxt.wp = ~st_r.wp;
		end
		if (pop) begin
			st_nxt.rp = ~st_r.rp;
		end
		st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : ihs_buf

//--- rtl/ihs_bank.sv
`timescale 1ns/100ps
module ihs_bank
	import ihs_pkg::*;
#(
	parameter int CW = CNT_W
) (
	// Clock and reset.
	input  wire logic             i_sys_clk,
	input  wire logic             i_arst_n,
	// Sampled pixel.
	input  wire logic             i_samp,
	input  wire logic [PIX_W-1:0] i_pix,
	input  wire logic [1:0]       i_par,
	input  wire logic             i_dw12,
	input  wire logic             i_clr,
	// Read port.
	input  wire logic [2:0]       i_rd_hist,
	input  wire logic [5:0]       i_rd_idx,
	output logic [CW-1:0]         o_rd_data
);
	typedef struct packed {
		logic [NUM_HIST-1:0][NUM_CNT-1:0][CW-1:0] cnt;
	} ihs_bank_st_t;

	ihs_bank_st_t st_r;
	ihs_bank_st_t st_nxt;
	logic [11:0]  maxv;
	logic [4:0]   bin;
	logic [2:0]   ph;

	assign maxv = i_dw12 ? MAX_12 : MAX_10;
	assign bin  = 5'(i_pix >> (i_dw12 ? SHIFT_12 : SHIFT_10)); // R14
	assign ph   = 3'(i_par) + 3'h1;
	assign o_rd_data = (i_rd_hist < HIST_MAX && i_rd_idx < 6'(NUM_CNT)) ?
		st_r.cnt[i_rd_hist][i_rd_idx] : '0;

	always_comb begin
		st_nxt = st_r;
		for (int h = 0; h < NUM_HIST; h++) begin
			if (i_clr) begin
				st_nxt.cnt[h] = '0;
			end else if (i_samp && (h == 0 || 3'(h) == ph)) begin // R3
				// Zero and full-scale pixels also land in the edge bins.
				if (i_pix == '0 && ~&st_r.cnt[h][0]) begin // R13 R16
					st_nxt.cnt[h][0] = st_r.cnt[h][0] + CW'(1);
				end
				if (i_pix == maxv && ~&st_r.cnt[h][NUM_CNT-1]) begin // R15 R16
					st_nxt.cnt[h][NUM_CNT-1] = st_r.cnt[h][NUM_CNT-1] + CW'(1);
				end
				if (~&st_r.cnt[h][6'(bin)+6'h1]) begin // R14
					st_nxt.cnt[h][6'(bin)+6'h1] = st_r.cnt[h][6'(bin)+6'h1] + CW'(1);
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : ihs_bank

//--- rtl/ihs_stats.sv
// Behaviour
// R1: Count 0 sends nothing; 1..5 send all-colour then four parity histograms.
// R2: Sparsity sets sample spacing; values below the channel count act as it.
// R3: Per frame, 32-bin histogram per parity group plus one over all colours.
// R4: Only long-exposure group pixels contribute.
// R5: Black and white clip counts accompany every histogram.
// R6: Separate top and bottom statistics blocks, both sent out.
// R7: Receiver merges top and bottom blocks into whole-array histograms.
// R8: Statistics only on first data channel per side, one histogram per row.
// R9: Statistics-valid flag is high while histogram words are on the channel.
// R10: Each element splits into two words, low part first, width by setting.
// R11: Element 0 is an all-ones start marker.
// R12: Element 1 is the histogram identifier 0 to 4.
// R13: Element 2 counts sampled pixels equal to zero.
// R14: Elements 3 to 34 are the 32 ascending equal bins.
// R15: Element 35 counts pixels at datapath full scale.
// R16: Zero pixels also count in bin 0, full-scale ones in bin 31.
// R17: An evenly spread pixel subset is sampled, spread set by sparsity.
// R18: Software sets sparsity 8; receiver compares bins relatively.
// R19: 71 words per histogram; last word of element 35 is never sent.
// R20: Word width code 1 gives 10 bits, code 2 gives 12 bits.
// R21: Elements go out strictly ascending, no gaps inside a histogram.
`timescale 1ns/100ps
module ihs_stats
	import ihs_pkg::*;
(
	// Clock and reset.
	input  wire logic                           i_sys_clk,
	input  wire logic                           i_arst_n,
	// Register port.
	input  wire logic                           i_reg_wr,
	input  wire logic [6:0]                     i_reg_addr,
	input  wire logic [7:0]                     i_reg_wdata,
	output logic [7:0]                          o_reg_rdata,
	// Mode settings from other registers.
	input  wire logic [1:0]                     i_output_word_width_sel,
	input  wire logic [1:0]                     i_datapath_width_sel,
	// Pixel stream, index 0 top half, index 1 bottom half.
	input  wire logic [NUM_HALF-1:0]            i_pix_valid,
	input  wire logic [NUM_HALF-1:0][PIX_W-1:0] i_pix_data,
	input  wire logic [NUM_HALF-1:0]            i_pix_row_odd,
	input  wire logic [NUM_HALF-1:0]            i_pix_col_odd,
	input  wire logic [NUM_HALF-1:0]            i_pix_long,
	// Frame timing.
	input  wire logic                           i_frame_end,
	input  wire logic                           i_row_start,
	// Statistics output.
	output logic [WORD_W-1:0]                   o_first_data_channel_top,
	output logic [WORD_W-1:0]                   o_first_data_channel_bot,
	output logic                                o_stats_valid_flag,
	input  wire logic                           i_rx_ready
);
	typedef struct packed {
		ihs_state_t                st;
		logic [2:0]                hist_count_select;
		logic [7:0]                stats_sampling_sparsity;
		logic [7:0]                rdata;
		logic [2:0]                nhist;
		logic [2:0]                hist;
		logic [5:0]                elem;
		logic                      part;
		logic [NUM_HALF-1:0][7:0]  samp_cnt;
	} ihs_st_t;

	ihs_st_t                         st_r;
	ihs_st_t                         st_nxt;
	logic [7:0]                      freq_eff;
	logic [NUM_HALF-1:0]             samp;
	logic [NUM_HALF-1:0][CNT_W-1:0]  rd_data;
	logic [NUM_HALF-1:0][CNT_W-1:0]  elem_val;
	logic [NUM_HALF-1:0][WORD_W-1:0] word;
	logic                            w12;
	logic                            dw12;
	logic                            push_valid;
	logic                            push_ready;
	logic                            push;
	logic                            clr;
	logic [5:0]                      rd_idx;

	assign w12  = (i_output_word_width_sel == WIDTH_SEL_12); // R20
	assign dw12 = (i_datapath_width_sel == WIDTH_SEL_12);
	// Settings below the channel count would overrun the per-side sampling grid.
	assign freq_eff = (st_r.stats_sampling_sparsity < SPARSITY_MIN) ?
		SPARSITY_MIN : st_r.stats_sampling_sparsity; // R2
	assign clr        = (st_r.st == S_CLR);
	assign push_valid = (st_r.st == S_SEND); // R9
	assign push       = push_valid && push_ready;
	assign rd_idx     = st_r.elem - ELEM_FIRST_CNT;
	assign o_reg_rdata = st_r.rdata;

	genvar g;
	generate
		for (g = 0; g < NUM_HALF; g++) begin : g_half // R6
			// Counters only run during the accumulate phase of each frame.
			assign samp[g] = (st_r.st == S_ACC) && i_pix_valid[g] &&
				(st_r.samp_cnt[g] >= freq_eff - 8'h01) && i_pix_long[g]; // R4 R17

			ihs_bank u_bank (
				.i_sys_clk (i_sys_clk),
				.i_arst_n  (i_arst_n),
				.i_samp    (samp[g]),
				.i_pix     (i_pix_data[g]),
				.i_par     ({i_pix_row_odd[g], i_pix_col_odd[g]}),
				.i_dw12    (dw12),
				.i_clr     (clr),
				.i_rd_hist (st_r.hist),
				.i_rd_idx  (rd_idx),
				.o_rd_data (rd_data[g])
			);

			always_comb begin
				if (st_r.elem == ELEM_MARK) begin
					elem_val[g] = '1; // R11
				end else if (st_r.elem == ELEM_ID) begin
					elem_val[g] = CNT_W'(st_r.hist); // R12
				end else begin
					elem_val[g] = rd_data[g]; // R5 R13 R14 R15
				end
				if (!st_r.part) begin
					word[g] = w12 ? elem_val[g][11:0] : (elem_val[g][11:0] & MASK_10); // R10
				end else begin
					word[g] = w12 ? elem_val[g][23:12] : {2'h0, elem_val[g][19:10]}; // R10
				end
			end
		end
	endgenerate

	// Two-entry buffer keeps words when the receiver stalls.
	ihs_buf #(
		.W (2*WORD_W)
	) u_buf (
		.i_sys_clk   (i_sys_clk),
		.i_arst_n    (i_arst_n),
		.i_in_valid  (push_valid),
		.i_in_data   ({word[1], word[0]}),
		.o_in_ready  (push_ready),
		.o_out_valid (o_stats_valid_flag), // R8 R9
		.o_out_data  ({o_first_data_channel_bot, o_first_data_channel_top}),
		.i_out_ready (i_rx_ready)
	);

	always_comb begin
		st_nxt = st_r;
		if (i_reg_wr && i_reg_addr == HIST_COUNT_ADDR) begin
			st_nxt.hist_count_select = i_reg_wdata[2:0];
		end
		if (i_reg_wr && i_reg_addr == SPARSITY_ADDR) begin
			st_nxt.stats_sampling_sparsity = i_reg_wdata;
		end
		case (i_reg_addr)
			HIST_COUNT_ADDR: st_nxt.rdata = {5'h00, st_r.hist_count_select};
			SPARSITY_ADDR:   st_nxt.rdata = st_r.stats_sampling_sparsity;
			default:         st_nxt.rdata = 8'h00;
		endcase
		for (int h = 0; h < NUM_HALF; h++) begin
			if (st_r.st != S_ACC) begin
				st_nxt.samp_cnt[h] = 8'h00;
			end else if (i_pix_valid[h]) begin
				if (st_r.samp_cnt[h] >= freq_eff - 8'h01) begin // R17
					st_nxt.samp_cnt[h] = 8'h00;
				end else begin
					st_nxt.samp_cnt[h] = st_r.samp_cnt[h] + 8'h01;
				end
			end
		end
		case (st_r.st)
			S_ACC: begin
				if (i_frame_end) begin
					st_nxt.hist  = 3'h0;
					st_nxt.nhist = (st_r.hist_count_select > HIST_MAX) ?
						HIST_MAX : st_r.hist_count_select;
					if (st_r.hist_count_select == 3'h0) begin // R1
						st_nxt.st = S_CLR;
					end else begin
						st_nxt.st = S_WAIT_ROW;
					end
				end
			end
			S_WAIT_ROW: begin
				if (i_row_start) begin // R8
					st_nxt.st   = S_SEND;
					st_nxt.elem = ELEM_MARK;
					st_nxt.part = 1'b0;
				end
			end
			S_SEND: begin
				if (push) begin
					// The last word of the full-scale element is dropped.
					if (st_r.elem == ELEM_LAST && !st_r.part) begin // R19
						st_nxt.hist = st_r.hist + 3'h1; // R1
						if (st_r.hist + 3'h1 >= st_r.nhist) begin
							st_nxt.st = S_CLR;
						end else begin
							st_nxt.st = S_WAIT_ROW;
						end
					end else if (st_r.part) begin
						st_nxt.part = 1'b0;
						st_nxt.elem = st_r.elem + 6'h01; // R21
					end else begin
						st_nxt.part = 1'b1; // R10
					end
				end
			end
			S_CLR: begin
				st_nxt.st = S_ACC;
			end
			default: begin
				st_nxt.st = S_ACC;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= '{st: S_ACC, hist_count_select: HIST_COUNT_RST,
				stats_sampling_sparsity: SPARSITY_RST, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	sequence s_first_half;
		push && !st_r.part;
	endsequence

	sequence s_second_half;
		push && st_r.part;
	endsequence

	property p_no_hist_when_zero;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(st_r.st == S_ACC && i_frame_end && st_r.hist_count_select == 3'h0)
			|=> (st_r.st == S_CLR) ##1 (st_r.st == S_ACC);
	endproperty
	a_no_hist_when_zero: assert property (p_no_hist_when_zero) // R1
		else $error("Statistics sent with count zero.");

	property p_sparsity_floor;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		samp[0] |-> (st_r.samp_cnt[0] >= (SPARSITY_MIN - 8'h01));
	endproperty
	a_sparsity_floor: assert property (p_sparsity_floor) // R2
		else $error("Sample taken closer than the minimum spacing.");

	property p_marker;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(push && st_r.elem == ELEM_MARK && w12) |-> (word[0] == MAX_12 && word[1] == MAX_12);
	endproperty
	a_marker: assert property (p_marker) // R11
		else $error("Start marker is not all ones.");

	property p_hist_id;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(s_first_half and (st_r.elem == ELEM_ID)) |-> (word[0] == 12'(st_r.hist));
	endproperty
	a_hist_id: assert property (p_hist_id) // R12
		else $error("Histogram identifier word is wrong.");

	property p_pairing;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(s_first_half and (st_r.elem != ELEM_LAST)) |=> (st_r.part && st_r.st == S_SEND);
	endproperty
	a_pairing: assert property (p_pairing) // R10
		else $error("Second word of an element did not follow.");

	property p_ascending;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		s_second_half |=> (st_r.elem == $past(st_r.elem) + 6'h01 && !st_r.part);
	endproperty
	a_ascending: assert property (p_ascending) // R21
		else $error("Elements not sent in ascending order.");

	property p_drop_last;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(push && st_r.elem == ELEM_LAST) |-> !st_r.part ##1 (st_r.st != S_SEND);
	endproperty
	a_drop_last: assert property (p_drop_last) // R19
		else $error("Final word of the full-scale element was sent.");

	property p_row_start;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(st_r.st == S_WAIT_ROW && i_row_start) |=> (st_r.st == S_SEND && st_r.elem == ELEM_MARK);
	endproperty
	a_row_start: assert property (p_row_start) // R8
		else $error("Histogram did not start at the row start.");

	property p_hold_on_stall;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_stats_valid_flag && !i_rx_ready) |=> (o_stats_valid_flag &&
			$stable(o_first_data_channel_top) && $stable(o_first_data_channel_bot));
	endproperty
	a_hold_on_stall: assert property (p_hold_on_stall) // R9
		else $error("Word changed while the receiver stalled.");

	property p_narrow_words;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_stats_valid_flag && !w12) |->
			((o_first_data_channel_top & ~MASK_10) == '0 &&
			(o_first_data_channel_bot & ~MASK_10) == '0);
	endproperty
	a_narrow_words: assert property (p_narrow_words) // R20
		else $error("Ten-bit word carries bits above its width.");

	property p_hist_total;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(push && st_r.elem == ELEM_LAST && !st_r.part) |=>
			((st_r.st == S_CLR) == (st_r.hist == st_r.nhist));
	endproperty
	a_hist_total: assert property (p_hist_total) // R1
		else $error("Wrong number of histograms sent for the frame.");
endmodule : ihs_stats

//--- verif/ihs_rx_model.sv
`timescale 1ns/100ps
module ihs_rx_model
	import ihs_pkg::*;
(
	// Clock, reset and bench control.
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_clr,
	input  wire logic              i_slow,
	input  wire logic              i_w12,
	// Statistics stream.
	input  wire logic [WORD_W-1:0] i_top,
	input  wire logic [WORD_W-1:0] i_bot,
	input  wire logic              i_valid,
	output logic                   o_ready
);
	logic [WORD_W-1:0] w_top [0:71];
	logic [WORD_W-1:0] w_bot [0:71];
	logic [24:0]       m     [0:35];
	int                n;
	int                cyc;
	int                t_first;
	int                t_last;

	function automatic logic [24:0] ev(input logic [11:0] lo, input logic [11:0] hi);
		return {13'h0, lo} | ({13'h0, hi} << (i_w12 ? 12 : 10));
	endfunction : ev

	// Paced stalls show that a held word is neither lost nor repeated.
	always @(posedge i_sys_clk) begin
		#1;
		o_ready = i_slow ? !o_ready : i_arst_n;
	end

	always @(posedge i_sys_clk) begin
		cyc++;
		if (i_clr) begin
			n = 0;
		end else if (i_valid && o_ready && n < 72) begin
			if (n == 0) t_first = cyc;
			t_last = cyc;
			w_top[n] = i_top;
			w_bot[n] = i_bot;
			n++;
		end
	end

	// The halves are summed; the full-scale element is incomplete and is dropped.
	always_comb begin
		for (int e = 0; e < 35; e++) begin
			m[e] = ev(w_top[2*e], w_top[2*e+1]) + ev(w_bot[2*e], w_bot[2*e+1]);
		end
		m[35] = 25'h0;
	end
endmodule : ihs_rx_model

//--- verif/ihs_stats_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD %0t value %0h expected %0h", $time, (a), (b)); end end
module ihs_stats_tb
	import ihs_pkg::*;
;
	logic                           clk = 1'b0;
	logic                           arst_n = 1'b0;
	logic                           reg_wr = 1'b0;
	logic [6:0]                     reg_addr = 7'h00;
	logic [7:0]                     reg_wdata = 8'h00;
	logic [7:0]                     rdata;
	logic [1:0]                     ow_sel = 2'h1;
	logic [1:0]                     dp_sel = 2'h1;
	logic [NUM_HALF-1:0]            pv = '0;
	logic [NUM_HALF-1:0][PIX_W-1:0] pd = '0;
	logic [NUM_HALF-1:0]            ro = '0;
	logic [NUM_HALF-1:0]            co = '0;
	logic [NUM_HALF-1:0]            lg = '0;
	logic                           fe = 1'b0;
	logic                           rs = 1'b0;
	logic [WORD_W-1:0]              top;
	logic [WORD_W-1:0]              bot;
	logic                           flag;
	logic                           ready;
	logic                           clr = 1'b0;
	logic                           slow = 1'b0;
	int                             n_fail = 0;
	int                             cmp_count = 0;
	int                             cyc = 0;

	always #2.5 clk = ~clk;

	ihs_stats ihs_stats_inst (.i_sys_clk(clk), .i_arst_n(arst_n), .i_reg_wr(reg_wr),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
		.i_output_word_width_sel(ow_sel), .i_datapath_width_sel(dp_sel),
		.i_pix_valid(pv), .i_pix_data(pd), .i_pix_row_odd(ro), .i_pix_col_odd(co),
		.i_pix_long(lg), .i_frame_end(fe), .i_row_start(rs),
		.o_first_data_channel_top(top), .o_first_data_channel_bot(bot),
		.o_stats_valid_flag(flag), .i_rx_ready(ready));

	ihs_rx_model rx (.i_sys_clk(clk), .i_arst_n(arst_n), .i_clr(clr), .i_slow(slow),
		.i_w12(ow_sel == 2'h2), .i_top(top), .i_bot(bot), .i_valid(flag), .o_ready(ready));

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	// The tests need about 1850 cycles; the ceiling of 20000 leaves ample margin.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask : wr

	task automatic rd(input logic [6:0] a);
		reg_addr = a;
		tick();
	endtask : rd

	task automatic feed(input int h, input int n, input logic [11:0] v,
		input logic r, input logic c, input logic l);
		pd[h] = v;
		ro[h] = r;
		co[h] = c;
		lg[h] = l;
		pv[h] = 1'b1;
		repeat (n) tick();
		pv[h] = 1'b0;
		tick();
	endtask : feed

	task automatic frame_end();
		fe = 1'b1;
		tick();
		fe = 1'b0;
		tick();
	endtask : frame_end

	task automatic send();
		clr = 1'b1;
		rs = 1'b1;
		tick();
		clr = 1'b0;
		rs = 1'b0;
		for (int i = 0; i < 400 && rx.n < 71; i++) tick();
		repeat (4) tick();
	endtask : send

	function automatic logic [23:0] ev(input logic b, input int e);
		logic [11:0] lo;
		logic [11:0] hi;
		lo = b ? rx.w_bot[2*e] : rx.w_top[2*e];
		hi = (e == 35) ? 12'h000 : (b ? rx.w_bot[2*e+1] : rx.w_top[2*e+1]);
		return {12'h000, lo} | ({12'h000, hi} << ((ow_sel == 2'h2) ? 12 : 10));
	endfunction : ev

	task automatic t_regs();
		rd(HIST_COUNT_ADDR);
		`CHK(rdata, 8'h00)
		rd(SPARSITY_ADDR);
		`CHK(rdata, 8'h08)
		wr(HIST_COUNT_ADDR, 8'hFF);
		rd(HIST_COUNT_ADDR);
		`CHK(rdata, 8'h07)
		wr(7'h10, 8'h5A);
		rd(7'h10);
		`CHK(rdata, 8'h00)
		wr(SPARSITY_ADDR, 8'h10);
		rd(SPARSITY_ADDR);
		`CHK(rdata, 8'h10)
	endtask : t_regs

	task automatic t_none();
		wr(HIST_COUNT_ADDR, 8'h00);
		frame_end();
		send();
		`CHK(rx.n, 0)
	endtask : t_none

	task automatic t_frame10();
		wr(HIST_COUNT_ADDR, 8'h02);
		wr(SPARSITY_ADDR, 8'h08);
		feed(0, 16, 12'h000, 1'b0, 1'b0, 1'b1);
		feed(0, 16, 12'h3FF, 1'b0, 1'b0, 1'b1);
		feed(1, 8, 12'h200, 1'b1, 1'b1, 1'b1);
		feed(1, 16, 12'h100, 1'b1, 1'b1, 1'b0);
		frame_end();
		send();
		`CHK(rx.n, 71)
		`CHK(rx.t_last - rx.t_first, 70)
		`CHK(ev(0, 0), 24'h0FFFFF)
		`CHK(ev(0, 1), 24'h000000)
		`CHK(ev(0, 2), 24'h000002)
		`CHK(ev(0, 3), 24'h000002)
		`CHK(ev(0, 34), 24'h000002)
		`CHK(ev(0, 35), 24'h000002)
		`CHK(ev(1, 19), 24'h000001)
		`CHK(ev(1, 11), 24'h000000)
		`CHK(rx.m[19], 25'h0000001)
		send();
		`CHK(ev(0, 1), 24'h000001)
		`CHK(ev(0, 3), 24'h000002)
		`CHK(ev(1, 19), 24'h000000)
	endtask : t_frame10

	task automatic t_frame12();
		ow_sel = 2'h2;
		dp_sel = 2'h2;
		slow = 1'b1;
		wr(HIST_COUNT_ADDR, 8'h05);
		wr(SPARSITY_ADDR, 8'h10);
		feed(0, 32, 12'hFFF, 1'b1, 1'b0, 1'b1);
		feed(1, 16, 12'h7FF, 1'b0, 1'b1, 1'b1);
		frame_end();
		for (int h = 0; h < 5; h++) begin
			send();
			`CHK(rx.n, 71)
			`CHK(ev(0, 1), 24'(h))
			`CHK(ev(1, 0), 24'hFFFFFF)
			`CHK(ev(0, 34), (h == 0 || h == 3) ? 24'h000002 : 24'h000000)
			`CHK(ev(0, 35), (h == 0 || h == 3) ? 24'h000002 : 24'h000000)
			`CHK(ev(1, 18), (h == 0 || h == 2) ? 24'h000001 : 24'h000000)
		end
		send();
		`CHK(rx.n, 0)
	endtask : t_frame12

	initial begin
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		tick();
		t_regs();
		t_none();
		t_frame10();
		t_frame12();
		summarize();
	end
endmodule : ihs_stats_tb
